// ==== verilog/interlock_pkg.sv ====
// Purpose: Shared constants for the panel interlock mode controller.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Parameter fields are held in one word; commands are write pulses.
//
// Summary of operation
// - Interlock function active only when mode select equals 7.
// - Active and connected: stop output in external mode; allow panel mode and writes.
// - Active and disconnected: force external mode; refuse panel mode requests.
// - Disconnect in panel mode switches to external regardless of start inputs.
// - After forced switch, run externally if a start input is already on.
// - External and stopped: connecting keeps it stopped and external; panel allowed.
// - External running: connect stops output, disconnect resumes with frequency signal.
// - Mode select leaving 7 in panel mode: ordinary stop input, ordinary switching.
// - Mode select 7 disables link operation; the power-on link 1 check sees only reset values (select 0, link 0), so it never enters external mode.
// - Refuse external-to-panel switch when connected and a start input is on.
// - Polarity 0 or 1 normal; 2 or 3 inverts connected meaning.
// - Forced panel-to-external switch resets the operator panel once.
// - Alarm reset only by panel stop key in panel mode.
// - Interlock function off when supply switch-over sequence is selected, except the link block: link_permit still drops at select 7.
// - Switch-over sequence selected when bypass parameter is 1 or 2.

`default_nettype none

package interlock_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_PARAM = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   // ------------------------------------------------------------
   // Parameter word fields
   // ------------------------------------------------------------
   localparam int MODE_SEL_LSB = 0;
   localparam int POL_LSB = 8;
   localparam int LINK_LSB = 12;
   localparam int BYPASS_LSB = 16;
   localparam logic [7:0] MODE_SEL_RST = 8'h00;
   localparam logic [3:0] POL_RST = 4'h0;
   localparam logic [3:0] LINK_RST = 4'h0;
   localparam logic [3:0] BYPASS_RST = 4'h0;

   // ------------------------------------------------------------
   // Parameter codes
   // ------------------------------------------------------------
   localparam logic [7:0] MODE_SEL_INTERLOCK = 8'h07;
   localparam logic [7:0] MODE_SEL_PANEL_FIXED = 8'h01;
   localparam logic [7:0] MODE_SEL_EXT_FIXED = 8'h02;
   localparam logic [3:0] POL_INV_LO = 4'h2;
   localparam logic [3:0] POL_INV_HI = 4'h3;
   localparam logic [3:0] LINK_EXT_AT_POWER_ON = 4'h1;
   localparam logic [3:0] BYPASS_SEQ_LO = 4'h1;
   localparam logic [3:0] BYPASS_SEQ_HI = 4'h2;

   // ------------------------------------------------------------
   // Command and status bits
   // ------------------------------------------------------------
   localparam int CMD_REQ_PANEL = 0;
   localparam int CMD_REQ_EXT = 1;
   localparam int CMD_PANEL_RUN = 2;
   localparam int CMD_STOP_KEY = 3;
   localparam int ST_PANEL_MODE = 0;
   localparam int ST_OUT_STOP = 1;
   localparam int ST_WR_PERMIT = 2;
   localparam int ST_RUN = 3;
   localparam int ST_IL_ACTIVE = 4;
   localparam int ST_CONNECTED = 5;
   localparam int ST_ALARM = 6;
   localparam int ST_REFUSED = 7;
   localparam int ST_LINK_PERMIT = 8;

   // ------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------
   localparam int SYNC_W = 3;
   localparam int SYNC_IL = 0;
   localparam int SYNC_FWD = 1;
   localparam int SYNC_REV = 2;

   typedef enum logic {MODE_EXTERNAL, MODE_PANEL} op_mode_e;

endpackage

`default_nettype wire

// ==== verilog/sync_if.sv ====
// Purpose: Carries raw terminal levels in and synchronised levels out.
// Assumes: Single clock domain.
// Notes:   Used between the controller and its input synchroniser.

`default_nettype none

interface sync_if #(parameter int W = 3);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport sync_side (input raw, output synced);
   modport user_side (output raw, input synced);
endinterface

`default_nettype wire

// ==== verilog/input_sync.sv ====
// Purpose: Two-flop synchroniser for the terminal inputs.
// Assumes: Inputs may change at any time relative to pclk.
// Notes:   The first stage feeds only the second stage.

`default_nettype none

module input_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Levels
   sync_if.sync_side sio
);

   logic [W-1:0] meta_r;
   logic [W-1:0] stable_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         stable_r <= '0;
      end else begin
         meta_r <= sio.raw;
         stable_r <= meta_r;
      end
   end

   assign sio.synced = stable_r;

endmodule

`default_nettype wire

// ==== verilog/panel_interlock_ctrl.sv ====
// Purpose: Operation-mode controller with panel interlock for a drive.
// Assumes: APB master per the protocol; terminals asynchronous to pclk.
// Notes:   Panel actions arrive as command writes; results are registered pins.
//
// Local design decisions: the register addresses and the APB interface to the registers.

`default_nettype none

module panel_interlock_ctrl (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Terminals
   input wire logic interlock_input,
   input wire logic forward_start_input,
   input wire logic reverse_start_input,
   input wire logic ext_freq_present,
   input wire logic alarm_in,
   // Drive side
   output logic panel_mode,
   output logic output_stop,
   output logic param_write_permit,
   output logic drive_run,
   output logic panel_reset,
   output logic link_permit,
   output logic alarm_active
);
   import interlock_pkg::*;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo,
                                     input logic [3:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   function automatic logic is_map_addr(input logic [7:0] a);
      is_map_addr = (a == OFS_PARAM) || (a == OFS_CMD) || (a == OFS_STATUS);
   endfunction

   function automatic logic reg_hit(input logic take, input logic [7:0] a,
                                    input logic [7:0] ofs);
      reg_hit = take && (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [7:0] mode_sel_r;
   logic [3:0] pol_r;
   logic [3:0] link_r;
   logic [3:0] bypass_r;
   logic [7:0] mode_sel_prev_r;
   op_mode_e mode_r;
   op_mode_e mode_nxt;
   logic boot_r;
   logic panel_run_r;
   logic alarm_r;
   logic refused_r;
   logic refuse_nxt;
   logic forced_nxt;
   logic out_stop_nxt;
   logic run_nxt;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic panel_mode_r;
   logic output_stop_r;
   logic wr_permit_r;
   logic drive_run_r;
   logic panel_reset_r;
   logic link_permit_r;
   logic wr_take;
   logic cmd_wr;
   logic req_panel;
   logic req_ext;
   logic req_run;
   logic stop_key;
   logic il_active;
   logic bypass_sel;
   logic invert;
   logic connected;
   logic start_any;
   logic leave_sel;
   logic [31:0] status_word;

   sync_if #(.W(SYNC_W)) sio();

   // ------------------------------------------------------------
   // Terminal synchronisation
   // ------------------------------------------------------------
   assign sio.raw[SYNC_IL] = interlock_input;
   assign sio.raw[SYNC_FWD] = forward_start_input;
   assign sio.raw[SYNC_REV] = reverse_start_input;

   input_sync #(.W(SYNC_W)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .sio(sio)
   );

   // ------------------------------------------------------------
   // Interlock qualification
   // ------------------------------------------------------------
   assign bypass_sel = in_range(bypass_r, BYPASS_SEQ_LO, BYPASS_SEQ_HI);
   assign il_active = (mode_sel_r == MODE_SEL_INTERLOCK) && !bypass_sel;
   assign invert = in_range(pol_r, POL_INV_LO, POL_INV_HI);
   assign connected = sio.synced[SYNC_IL] ^ invert;
   assign start_any = sio.synced[SYNC_FWD] | sio.synced[SYNC_REV];
   assign leave_sel = (mode_sel_prev_r == MODE_SEL_INTERLOCK) &&
                      (mode_sel_r != MODE_SEL_INTERLOCK);

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   // One wait-free access cycle: the answer is prepared during setup, so the
   // read data comes from a flop at the cost of nothing on the master side.
   assign wr_take = psel && penable && pready_r && pwrite && !pslverr_r;
   assign cmd_wr = reg_hit(wr_take, paddr, OFS_CMD);
   assign req_panel = cmd_wr && pwdata[CMD_REQ_PANEL];
   assign req_ext = cmd_wr && pwdata[CMD_REQ_EXT];
   assign req_run = cmd_wr && pwdata[CMD_PANEL_RUN];
   assign stop_key = cmd_wr && pwdata[CMD_STOP_KEY];

   always_comb begin
      status_word = '0;
      status_word[ST_PANEL_MODE] = panel_mode_r;
      status_word[ST_OUT_STOP] = output_stop_r;
      status_word[ST_WR_PERMIT] = wr_permit_r;
      status_word[ST_RUN] = drive_run_r;
      status_word[ST_IL_ACTIVE] = il_active;
      status_word[ST_CONNECTED] = connected;
      status_word[ST_ALARM] = alarm_r;
      status_word[ST_REFUSED] = refused_r;
      status_word[ST_LINK_PERMIT] = link_permit_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else if (psel && !penable) begin
         pready_r <= 1'b1;
         pslverr_r <= !is_map_addr(paddr);
         prdata_r <= '0;
         if (!pwrite) begin
            unique case (paddr)
               OFS_PARAM: begin
                  prdata_r[MODE_SEL_LSB +: 8] <= mode_sel_r;
                  prdata_r[POL_LSB +: 4] <= pol_r;
                  prdata_r[LINK_LSB +: 4] <= link_r;
                  prdata_r[BYPASS_LSB +: 4] <= bypass_r;
               end
               OFS_STATUS: begin
                  prdata_r <= status_word;
               end
               default: begin
                  prdata_r <= '0;
               end
            endcase
         end
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Parameter word
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sel_r <= MODE_SEL_RST;
         pol_r <= POL_RST;
         link_r <= LINK_RST;
         bypass_r <= BYPASS_RST;
      end else if (reg_hit(wr_take, paddr, OFS_PARAM)) begin
         mode_sel_r <= pwdata[MODE_SEL_LSB +: 8];
         pol_r <= pwdata[POL_LSB +: 4];
         link_r <= pwdata[LINK_LSB +: 4];
         bypass_r <= pwdata[BYPASS_LSB +: 4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sel_prev_r <= MODE_SEL_RST;
         boot_r <= 1'b1;
      end else begin
         mode_sel_prev_r <= mode_sel_r;
         boot_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Operation mode
   // ------------------------------------------------------------
   // Only a change away from select 7 moves the mode; a later change between
   // ordinary codes keeps the mode until software requests a switch.
   always_comb begin
      mode_nxt = mode_r;
      refuse_nxt = 1'b0;
      forced_nxt = 1'b0;
      if (boot_r) begin
         if (il_active && (link_r == LINK_EXT_AT_POWER_ON)) begin
            mode_nxt = MODE_EXTERNAL;
         end
      end else if (il_active && !connected && (mode_r == MODE_PANEL)) begin
         mode_nxt = MODE_EXTERNAL;
         forced_nxt = 1'b1;
      end else if (leave_sel) begin
         if (mode_sel_r == MODE_SEL_PANEL_FIXED) begin
            mode_nxt = MODE_PANEL;
         end else if (mode_sel_r == MODE_SEL_EXT_FIXED) begin
            mode_nxt = MODE_EXTERNAL;
         end
      end else if (req_panel) begin
         if (il_active && (!connected || start_any)) begin
            refuse_nxt = 1'b1;
         end else if (!il_active &&
                      ((mode_sel_r == MODE_SEL_EXT_FIXED) || drive_run_r)) begin
            refuse_nxt = 1'b1;
         end else begin
            mode_nxt = MODE_PANEL;
         end
      end else if (req_ext) begin
         if (!il_active &&
             ((mode_sel_r == MODE_SEL_PANEL_FIXED) || drive_run_r)) begin
            refuse_nxt = 1'b1;
         end else begin
            mode_nxt = MODE_EXTERNAL;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= MODE_PANEL;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Refused requests are remembered until software writes a one to clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_r <= 1'b0;
      end else if (refuse_nxt) begin
         refused_r <= 1'b1;
      end else if (reg_hit(wr_take, paddr, OFS_STATUS) && pwdata[ST_REFUSED]) begin
         refused_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Panel run and alarm
   // ------------------------------------------------------------
   // A forced leave of panel mode drops the panel run, so a stopped or running
   // drive then runs only if a start terminal and the frequency signal are on.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_run_r <= 1'b0;
      end else if (mode_nxt != MODE_PANEL || stop_key) begin
         panel_run_r <= 1'b0;
      end else if (req_run && !alarm_r) begin
         panel_run_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_r <= 1'b0;
      end else if (alarm_in) begin
         alarm_r <= 1'b1;
      end else if (stop_key && (mode_r == MODE_PANEL)) begin
         alarm_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Output stop and run
   // ------------------------------------------------------------
   always_comb begin
      if (il_active) begin
         out_stop_nxt = connected && (mode_nxt == MODE_EXTERNAL);
      end else begin
         out_stop_nxt = connected;
      end
      if (alarm_r || out_stop_nxt) begin
         run_nxt = 1'b0;
      end else if (mode_nxt == MODE_PANEL) begin
         run_nxt = panel_run_r && !stop_key;
      end else begin
         run_nxt = start_any && ext_freq_present;
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_mode_r <= 1'b1;
         output_stop_r <= 1'b0;
         wr_permit_r <= 1'b0;
         drive_run_r <= 1'b0;
         panel_reset_r <= 1'b0;
         link_permit_r <= 1'b0;
      end else begin
         panel_mode_r <= (mode_nxt == MODE_PANEL);
         output_stop_r <= out_stop_nxt;
         wr_permit_r <= (mode_nxt == MODE_PANEL) && connected;
         drive_run_r <= run_nxt;
         panel_reset_r <= forced_nxt;
         link_permit_r <= (mode_sel_r != MODE_SEL_INTERLOCK);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign panel_mode = panel_mode_r;
   assign output_stop = output_stop_r;
   assign param_write_permit = wr_permit_r;
   assign drive_run = drive_run_r;
   assign panel_reset = panel_reset_r;
   assign link_permit = link_permit_r;
   assign alarm_active = alarm_r;

endmodule

`default_nettype wire

// ==== tb/panel_interlock_checker.sv ====
// Purpose: Concurrent checks on the mode controller's ports.
// Assumes: One clock domain; parameter writes are seen on the APB pins.
// Notes:   A shadow bit tracks mode select 7, since the register is internal.

`default_nettype none

module panel_interlock_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Drive side
   input wire logic panel_mode,
   input wire logic output_stop,
   input wire logic param_write_permit,
   input wire logic drive_run,
   input wire logic panel_reset,
   input wire logic link_permit,
   input wire logic alarm_active
);
   import interlock_pkg::*;
   logic sel7_r;

   // Shadow of mode select; updated at the same edge the design takes the write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sel7_r <= 1'b0;
      else if (psel && penable && pready && pwrite && !pslverr && paddr == OFS_PARAM)
         sel7_r <= (pwdata[7:0] == MODE_SEL_INTERLOCK);
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_pready; psel && !penable |=> pready && penable; endproperty
   a_pready: assert property (p_pready) else $error("no ready after setup");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_reset_cause;
      panel_reset |-> !panel_mode && $past(panel_mode) && $past(sel7_r);
   endproperty
   a_reset_cause: assert property (p_reset_cause) else $error("panel reset w/o switch");
   property p_reset_once; panel_reset |=> !panel_reset; endproperty
   a_reset_once: assert property (p_reset_once) else $error("panel reset too long");
   property p_permit; param_write_permit |-> panel_mode; endproperty
   a_permit: assert property (p_permit) else $error("write permit outside panel");
   property p_stop_run; output_stop |-> !drive_run; endproperty
   a_stop_run: assert property (p_stop_run) else $error("running while stopped");
   property p_link; sel7_r && $past(sel7_r) |-> !link_permit; endproperty
   a_link: assert property (p_link) else $error("link permitted at select 7");
   property p_alarm_clear; $fell(alarm_active) |-> $past(panel_mode); endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("alarm cleared external");
   property p_alarm_run; alarm_active |=> !drive_run; endproperty
   a_alarm_run: assert property (p_alarm_run) else $error("running under alarm");

   c_forced: cover property (panel_reset);
   c_alarm_clear: cover property ($fell(alarm_active));
   c_slverr: cover property (pslverr);
endmodule

`default_nettype wire

// ==== tb/terminal_model.sv ====
// Purpose: External terminals facing the controller.
// Assumes: Levels change just after a clock edge, like real slow contacts.
// Notes:   The alarm is a one-cycle event; reset comes only via the panel.

`default_nettype none

module terminal_model (
   // Clock
   input wire logic pclk,
   // Terminal levels
   output logic interlock_input,
   output logic forward_start_input,
   output logic reverse_start_input,
   output logic ext_freq_present,
   output logic alarm_in
);
   initial begin
      interlock_input = 1'b0;
      forward_start_input = 1'b0;
      reverse_start_input = 1'b0;
      ext_freq_present = 1'b0;
      alarm_in = 1'b0;
   end

   task automatic set(input logic il, input logic f, input logic r, input logic q);
      @(posedge pclk);
      interlock_input <= il;
      forward_start_input <= f;
      reverse_start_input <= r;
      ext_freq_present <= q;
   endtask

   // The alarm input is raised here for one cycle only; clearing the latched alarm is the panel's job.
   task automatic alarm_pulse();
      @(posedge pclk);
      alarm_in <= 1'b1;
      @(posedge pclk);
      alarm_in <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ==== tb/test_panel_interlock_ctrl.sv ====
// Purpose: Self-checking bench for the panel interlock mode controller.
// Assumes: Terminal changes show at the pins three edges later.
// Notes:   Scenarios run in order; each leaves the state the next expects.

`default_nettype none

`define CK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin miscompares++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, sn); end end

module test_panel_interlock_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import interlock_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic interlock_input, forward_start_input, reverse_start_input, ext_freq_present;
   logic alarm_in, panel_mode, output_stop, param_write_permit, drive_run;
   logic panel_reset, link_permit, alarm_active;
   int miscompares = 0;
   int n_checks = 0;

   always #2 pclk = ~pclk;

   panel_interlock_ctrl u_panel_interlock_ctrl (.pclk, .presetn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .interlock_input, .forward_start_input,
      .reverse_start_input, .ext_freq_present, .alarm_in, .panel_mode, .output_stop,
      .param_write_permit, .drive_run, .panel_reset, .link_permit, .alarm_active);
   terminal_model u_terminal_model (.pclk, .interlock_input, .forward_start_input,
      .reverse_start_input, .ext_freq_present, .alarm_in);

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Holds the request until pready is seen, then idles one cycle.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         miscompares++;
         wrap_up();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic cmd(input int b);
      apb(1'b1, OFS_CMD, 32'h1 << b);
      tick(2);
   endtask

   task automatic prm(input logic [7:0] s, input logic [3:0] p, input logic [3:0] b);
      apb(1'b1, OFS_PARAM, {12'h000, b, 4'h0, p, s});
      tick(3);
   endtask

   task automatic term(input logic il, input logic f, input logic q);
      u_terminal_model.set(il, f, 1'b0, q);
      tick(4);
   endtask

   task automatic s_regs();
      `CK("mode", 1'b1, panel_mode)
      `CK("link", 1'b1, link_permit)
      apb(1'b1, 8'h10, 32'hFFFF_FFFF);
      `CK("wr err", 1'b1, err)
      apb(1'b0, 8'h10, 32'h0);
      `CK("rd err", 1'b1, err)
      apb(1'b0, OFS_PARAM, 32'h0);
      `CK("param", 32'h0000_0000, rd)
      apb(1'b0, OFS_CMD, 32'h0);
      `CK("cmd", 32'h0000_0000, rd)
   endtask

   task automatic s_forced();
      term(1'b1, 1'b1, 1'b1);
      prm(MODE_SEL_INTERLOCK, 4'h0, 4'h0);
      `CK("link", 1'b0, link_permit)
      `CK("mode", 1'b1, panel_mode)
      `CK("permit", 1'b1, param_write_permit)
      term(1'b0, 1'b1, 1'b1);
      `CK("preset", 1'b1, panel_reset)
      `CK("mode", 1'b0, panel_mode)
      `CK("run", 1'b1, drive_run)
      `CK("permit", 1'b0, param_write_permit)
      tick(1);
      `CK("preset", 1'b0, panel_reset)
      cmd(CMD_REQ_PANEL);
      `CK("mode", 1'b0, panel_mode)
      apb(1'b0, OFS_STATUS, 32'h0);
      `CK("refused", 1'b1, rd[ST_REFUSED])
      apb(1'b1, OFS_STATUS, 32'h0000_0080);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CK("refused clr", 1'b0, rd[ST_REFUSED])
   endtask

   task automatic s_ext_run();
      term(1'b1, 1'b1, 1'b1);
      `CK("stop", 1'b1, output_stop)
      `CK("run", 1'b0, drive_run)
      cmd(CMD_REQ_PANEL);
      `CK("mode", 1'b0, panel_mode)
      term(1'b0, 1'b1, 1'b1);
      `CK("run", 1'b1, drive_run)
      term(1'b0, 1'b0, 1'b1);
      term(1'b1, 1'b0, 1'b1);
      `CK("stop", 1'b1, output_stop)
      `CK("mode", 1'b0, panel_mode)
      cmd(CMD_REQ_PANEL);
      `CK("mode", 1'b1, panel_mode)
   endtask

   task automatic s_pol_alarm();
      prm(MODE_SEL_INTERLOCK, POL_INV_LO, 4'h0);
      `CK("mode", 1'b0, panel_mode)
      term(1'b0, 1'b0, 1'b0);
      cmd(CMD_REQ_PANEL);
      `CK("mode", 1'b1, panel_mode)
      term(1'b1, 1'b0, 1'b0);
      u_terminal_model.alarm_pulse();
      tick(3);
      `CK("alarm", 1'b1, alarm_active)
      cmd(CMD_STOP_KEY);
      `CK("alarm", 1'b1, alarm_active)
      term(1'b0, 1'b0, 1'b0);
      cmd(CMD_REQ_PANEL);
      cmd(CMD_STOP_KEY);
      `CK("alarm", 1'b0, alarm_active)
      cmd(CMD_PANEL_RUN);
      `CK("run", 1'b1, drive_run)
   endtask

   task automatic s_bypass();
      logic [3:0] byp [3] = '{BYPASS_SEQ_LO, BYPASS_SEQ_HI, 4'h0};
      foreach (byp[i]) begin
         prm(MODE_SEL_INTERLOCK, POL_INV_HI, byp[i]);
         apb(1'b0, OFS_STATUS, 32'h0);
         `CK("active", (i == 2), rd[ST_IL_ACTIVE])
      end
   endtask

   task automatic s_leave();
      prm(MODE_SEL_PANEL_FIXED, POL_INV_HI, 4'h0);
      `CK("stop", 1'b1, output_stop)
      `CK("link", 1'b1, link_permit)
      cmd(CMD_REQ_EXT);
      `CK("mode", 1'b1, panel_mode)
      prm(MODE_SEL_INTERLOCK, POL_INV_HI, 4'h0);
      prm(MODE_SEL_EXT_FIXED, POL_INV_HI, 4'h0);
      `CK("mode", 1'b0, panel_mode)
   endtask

   initial begin
      tick(10);
      presetn <= 1'b1;
      tick(2);
      s_regs();
      s_forced();
      s_ext_run();
      s_pol_alarm();
      s_bypass();
      s_leave();
      wrap_up();
   end
endmodule

bind panel_interlock_ctrl panel_interlock_checker u_panel_interlock_checker (.pclk, .presetn,
   .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr, .panel_mode, .output_stop,
   .param_write_permit, .drive_run, .panel_reset, .link_permit, .alarm_active);

`default_nettype wire
